// File: sim/sepp_spi_master.sv
/*
  Bus master model: frames of whole or torn bytes in mode 0,0 or 1,1, optional pause.
  Assumes mclk of 4 ns; one link bit is 16 mclk, a 64 ns link clock.
*/
`timescale 1ns/1ps
module sepp_spi_master (
  input wire logic mclk,
  input wire logic sdoOut,
  input wire logic sdoOeN,
  output logic selN,
  output logic sclk,
  output logic sdi,
  output logic pauseN
);
  logic cpol = 1'h0;
  logic oePaused = 1'h0;
  logic [39:0] rxq = '0;

  // Select low from power-up: no falling edge before the first frame ends
  initial begin
    selN = 1'h0;
    sclk = 1'h0;
    sdi = 1'h0;
    pauseN = 1'h1;
  end

  task automatic halfBit();
    repeat (8) @(negedge mclk);
  endtask : halfBit

  // Clock parked low for the pause; garbage edges and data while paused
  task automatic pauseHere(input bit dropSel);
    sclk <= 1'h0;
    halfBit();
    pauseN <= 1'h0;
    halfBit();
    repeat (3) begin
      sclk <= 1'h1;
      sdi <= ~sdi;
      halfBit();
      sclk <= 1'h0;
      halfBit();
    end
    oePaused = sdoOeN;
    selN <= dropSel;
    halfBit();
    pauseN <= 1'h1;
    halfBit();
  endtask : pauseHere

  // Whole bytes MSB first unless a torn frame is wanted
  task automatic frame(input int nb, input logic [39:0] d, input int pauseAt, input bit dropSel);
    sclk <= cpol; // Idle clock level of the mode
    halfBit();
    selN <= 1'h0;
    halfBit();
    for (int i = 0; i <= nb; i++) begin
      if (i == pauseAt) begin
        pauseHere(dropSel);
      end
      if (i == nb || (dropSel && i == pauseAt)) begin
        break;
      end
      sclk <= 1'h0;
      sdi <= d[39 - i];
      halfBit();
      rxq = {rxq[38:0], sdoOeN | sdoOut}; // Pull-up holds the released output high
      sclk <= 1'h1; // Device takes data on this rise in both modes
      halfBit();
    end
    sclk <= cpol;
    halfBit();
    selN <= 1'h1;
    sdi <= ~sdi; // Released data line does not keep its last level
    halfBit();
  endtask : frame

endmodule : sepp_spi_master

// File: sim/spi_eeprom_protocol_protect_bench.sv
/*
  Self-checking bench: command frames through the master model, status and write checks.
  Assumes the master model is compiled first and a 2 us write cycle (500 mclk).
*/
`timescale 1ns/1ps
module spi_eeprom_protocol_protect_bench;
  import sepp_pkg::*;
  logic mclk, reset_n, wprotN, selN, sclk, sdi, pauseN, sdoOut, sdoOeN, standby;
  logic wrByteStb, wrCommit, wrAbort;
  logic [7:0] statusOut, s, wrByte, lastWr;
  logic [1:0] memSpace;
  logic [7:0] memRdData = 8'h00;
  logic [9:0] memAddr;
  logic [9:0] protA [3];
  int miscompares, nTests, nCommit, nAbort, nStb, n0;

  sepp_top #(.WRITE_CYCLE_US(2)) DUT (.mclk(mclk), .reset_n(reset_n), .selN(selN), .sclk(sclk),
    .sdi(sdi), .pauseN(pauseN), .wprotN(wprotN), .memRdData(memRdData), .sdoOut(sdoOut),
    .sdoOeN(sdoOeN), .standby(standby), .memAddr(memAddr), .memSpace(memSpace),
    .wrByteStb(wrByteStb), .wrByte(wrByte), .wrCommit(wrCommit), .wrAbort(wrAbort),
    .statusOut(statusOut));
  sepp_spi_master M (.mclk(mclk), .sdoOut(sdoOut), .sdoOeN(sdoOeN), .selN(selN), .sclk(sclk),
    .sdi(sdi), .pauseN(pauseN));

  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end

  // Memory stand-in: data is a fixed function of the address
  always @(negedge mclk) memRdData <= memAddr[7:0] ^ 8'h5A;

  always @(posedge mclk) begin
    nCommit += int'(wrCommit === 1'b1);
    nAbort += int'(wrAbort === 1'b1);
    nStb += int'(wrByteStb === 1'b1);
    if (wrByteStb === 1'b1) begin
      lastWr = wrByte;
    end
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      miscompares++;
    end
  endtask : chk

  task automatic finishTest();
    if (miscompares == 0 && nTests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finishTest

  task automatic cmd(input int nb, input logic [39:0] d);
    M.frame(nb, d, -1, 1'b0);
  endtask : cmd

  task automatic arm();
    cmd(8, {OP_WRITE_ARM, 32'h0});
  endtask : arm

  task automatic rdStatus(output logic [7:0] v);
    cmd(16, {OP_STATUS_READ, 32'h0});
    v = M.rxq[7:0];
  endtask : rdStatus

  // Bounded busy polling; a stuck busy flag shows as a miscompare
  task automatic waitReady();
    s = 8'h01;
    for (int k = 0; k < 8 && s[0] !== 1'b0; k++) begin
      rdStatus(s); // Busy polled during the cycle
    end
    chk("ready", {7'h0, s[0]}, 8'h00); // Busy ends
  endtask : waitReady

  task automatic wrStatus(input logic [7:0] v, input logic [7:0] exp);
    arm();
    cmd(16, {OP_STATUS_WRITE, v, 24'h0});
    waitReady();
    rdStatus(s);
    chk("status after write", s & 8'hFD, exp); // Arm bit masked: discard may keep it
  endtask : wrStatus

  task automatic wrTry(input int nb, input logic [9:0] a, input bit armIt, input int expC,
                       input int expA);
    int c0;
    int a0;
    c0 = nCommit;
    a0 = nAbort;
    if (armIt) begin
      arm();
    end
    cmd(nb, {OP_MEM_WRITE, 6'h0, a, 8'h3C, 8'hC3});
    chk("commit count", 8'(nCommit - c0), 8'(expC));
    chk("abort count", 8'(nAbort - a0), 8'(expA));
    waitReady();
  endtask : wrTry

  // Watchdog well beyond the roughly 26k cycles the sequence needs
  initial begin
    repeat (80000) @(posedge mclk);
    miscompares++;
    finishTest();
  end

  initial begin
    reset_n = 1'h0;
    wprotN = 1'h1;
    protA = '{10'h300, 10'h200, 10'h000};
    repeat (6) @(negedge mclk);
    reset_n = 1'h1;
    repeat (4) @(negedge mclk);
    chk("idle pins", {statusOut[1:0], 4'h0, sdoOeN, standby}, 8'h03); // Reset
    arm();
    rdStatus(s);
    chk("arm without select fall", s, 8'h00);
    for (int m = 0; m < 2; m++) begin
      M.cpol = m[0];
      arm();
      cmd(32, {OP_STATUS_READ, 32'h0});
      chk("status read", M.rxq[23:16], 8'h02); // Both modes
      chk("status repeat", M.rxq[7:0], 8'h02); // Output runs on
      cmd(8, {OP_WRITE_DISARM, 32'h0});
      rdStatus(s);
      chk("after disarm", s, 8'h00); // Disarm clears latch
    end
    arm();
    n0 = nStb;
    cmd(40, {OP_MEM_WRITE, 8'h01, 8'h10, 8'h55, 8'h66});
    chk("busy standby", {statusOut[0], 6'h0, standby}, 8'h80);
    chk("byte strobes", 8'(nStb - n0), 8'h02); // Whole data bytes
    chk("last data byte", lastWr, 8'h66);
    chk("write address", memAddr[7:0], 8'h12);
    rdStatus(s);
    chk("status in write", s, 8'h03); // Busy readable
    waitReady();
    chk("after write", {statusOut[1], 6'h0, standby}, 8'h01);
    wrTry(32, 10'h010, 1'b0, 0, 1); // Unarmed write refused
    wrTry(36, 10'h020, 1'b1, 0, 1); // Torn data byte
    wrTry(24, 10'h030, 1'b1, 0, 1); // No data byte
    for (int z = 1; z < 4; z++) begin
      wrStatus(8'(z << 2), 8'(z << 2)); // Size set
      wrTry(32, protA[z - 1], 1'b1, 0, 1); // Protected start
      wrTry(32, protA[z - 1] - 10'h1, 1'b1, int'(z < 3), int'(z == 3)); // Edge
    end
    @(negedge mclk);
    wprotN = 1'h0;
    wrStatus(8'hF3, 8'h80); // Lock 0 writable
    wrStatus(8'h0C, 8'h80); // Frozen
    @(negedge mclk);
    wprotN = 1'h1;
    wrStatus(8'h00, 8'h00); // Pin high unfreezes
    arm();
    M.frame(32, {OP_STATUS_READ, 32'h0}, 12, 1'b0);
    chk("paused enable", {7'h0, M.oePaused}, 8'h01); // Output floats
    chk("status across pause", M.rxq[23:16], 8'h02); // Count kept
    M.frame(8, {OP_WRITE_DISARM, 32'h0}, 8, 1'b1);
    rdStatus(s);
    chk("dropped in pause", s, 8'h02); // Command dropped
    cmd(40, {OP_MEM_READ, 8'h03, 8'hFF, 16'h0});
    chk("read byte", M.rxq[15:8], 8'hA5); // Read data
    chk("read rollover", M.rxq[7:0], 8'h5A); // Address wraps
    cmd(40, {OP_IDENT_READ, 8'h00, 8'h1F, 16'h0});
    chk("ident byte", M.rxq[15:8], 8'h45);
    chk("ident wrap", M.rxq[7:0], 8'h5A); // Page wraps in 32 bytes
    chk("ident space", {6'h0, memSpace}, 8'h01);
    finishTest();
  end

endmodule : spi_eeprom_protocol_protect_bench

// File: src/sepp_pin_sync.sv
/*
  Two flip-flop synchroniser for a group of pin inputs.
  Assumes the inputs are quasi-static levels relative to the sampling clock.
*/
`timescale 1ns/1ps
module sepp_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule : sepp_pin_sync

// File: src/sepp_pkg.sv
/*
  Constants, encodings and helpers shared by the serial memory protocol front end.
  Assumes a single system clock of 4 ns and nothing else of the surroundings.
*/
package sepp_pkg;

  localparam int CLK_PERIOD_NS = 4;
  // Default write cycle length; arbitrary, shortened through the top parameter
  localparam int WRITE_CYCLE_US_DEF = 5000;
  localparam int NS_PER_US = 1000;
  localparam int BUSY_CNT_W = 24;

  localparam logic [7:0] OP_WRITE_ARM = 8'h06;
  localparam logic [7:0] OP_WRITE_DISARM = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_MEM_READ = 8'h03;
  localparam logic [7:0] OP_MEM_WRITE = 8'h02;
  localparam logic [7:0] OP_IDENT_READ = 8'h83;
  localparam logic [7:0] OP_IDENT_WRITE = 8'h82;

  localparam int ST_LOCK_BIT = 7;
  localparam int ST_PSIZE_HI = 3;
  localparam int ST_PSIZE_LO = 2;
  localparam int ST_WEL_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int LOCK_SEL_BIT = 7;

  localparam logic LOCK_RST = 1'h0;
  localparam logic [1:0] PSIZE_RST = 2'h0;
  localparam logic WEL_RST = 1'h0;

  localparam logic [1:0] PS_NONE = 2'h0;
  localparam logic [1:0] PS_QUARTER = 2'h1;
  localparam logic [1:0] PS_HALF = 2'h2;
  localparam logic [1:0] PS_ALL = 2'h3;
  localparam logic [9:0] QUARTER_BASE = 10'h300;
  localparam logic [9:0] HALF_BASE = 10'h200;
  localparam logic [9:0] IDENT_ADDR_MASK = 10'h01F;

  typedef enum logic [1:0] {
    SP_ARRAY = 2'b00,
    SP_IDENT = 2'b01,
    SP_LOCK = 2'b10
  } sepp_space_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_OPCODE = 3'b001,
    S_ADDR = 3'b010,
    S_WDATA = 3'b011,
    S_RDATA = 3'b100,
    S_ONEBYTE = 3'b101,
    S_WAIT = 3'b110
  } sepp_state_t;

  typedef enum logic [2:0] {
    C_NONE = 3'b000,
    C_ARM = 3'b001,
    C_DISARM = 3'b010,
    C_SREAD = 3'b011,
    C_SWRITE = 3'b100,
    C_MREAD = 3'b101,
    C_MWRITE = 3'b110
  } sepp_cmd_t;

  function automatic logic sepp_protected(input logic [1:0] psize, input sepp_space_t space,
                                          input logic [9:0] addr);
    logic hit;
    hit = 1'h0;
    if (psize == PS_ALL) begin
      hit = 1'h1;
    end else if (space != SP_ARRAY) begin
      hit = 1'h0;
    end else if (psize == PS_HALF) begin
      hit = (addr >= HALF_BASE);
    end else if (psize == PS_QUARTER) begin
      hit = (addr >= QUARTER_BASE);
    end
    return hit;
  endfunction : sepp_protected

endpackage : sepp_pkg

// File: src/sepp_top.sv
/*
  Serial bus slave front end of a small nonvolatile memory: framing, pause, standby,
  write arming and the status/protect register.
  Assumes pins arrive asynchronously to mclk, serial clock well below mclk/4, and
  memory array storage outside, fed through the staging strobes below.
*/
`timescale 1ns/1ps
module sepp_top
  import sepp_pkg::*;
#(
  parameter int unsigned WRITE_CYCLE_US = WRITE_CYCLE_US_DEF
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic selN,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic pauseN,
  input wire logic wprotN,
  input wire logic [7:0] memRdData,
  output logic sdoOut,
  output logic sdoOeN,
  output logic standby,
  output logic [9:0] memAddr,
  output logic [1:0] memSpace,
  output logic wrByteStb,
  output logic [7:0] wrByte,
  output logic wrCommit,
  output logic wrAbort,
  output logic [7:0] statusOut
);
  localparam int unsigned WRITE_CYCLES =
    (WRITE_CYCLE_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  logic rstMeta_q, rstN_q;
  logic [4:0] pinS;
  logic selNS, sclkS, sdiS, pauseNS, wprotNS;
  logic selPrev_q, sclkPrev_q, selActive_q, paused_q;
  logic selFall, selRise, sclkRise, sclkFall;
  sepp_state_t state_q;
  sepp_cmd_t cmd_q;
  sepp_space_t space_q;
  logic [2:0] bitCnt_q, outCnt_q;
  logic [7:0] shiftIn_q, outSh_q, byteIn, loadByte, statusWord;
  logic [1:0] addrHi_q, newPsize_q, psize_q;
  logic addrCnt_q, gotData_q, newLock_q, lock_q, wel_q, busy_q, statusCyc_q;
  logic [9:0] memAddr_q, startAddr_q;
  logic wrByteStb_q, wrCommit_q, wrAbort_q, sdoOut_q, sdoOeN_q, outLoaded_q, standby_q;
  logic [7:0] wrByte_q, statusOut_q;
  logic [BUSY_CNT_W-1:0] busyCnt_q;
  logic frozen, frameEnd, commitOk, memCommit, statCommit, armDone;

  function automatic logic [9:0] stepAddr(input sepp_space_t sp, input logic [9:0] a);
    logic [9:0] n;
    n = a + 10'h001;
    if (sp != SP_ARRAY) begin
      n = n & IDENT_ADDR_MASK;
    end
    return n;
  endfunction : stepAddr

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_q <= 1'h0;
      rstN_q <= 1'h0;
    end else begin
      rstMeta_q <= 1'h1;
      rstN_q <= rstMeta_q;
    end
  end

  sepp_pin_sync #(
    .W(5),
    .RST_VAL(5'h00)
  ) uPinSync (
    .clk(mclk),
    .rstN(rstN_q),
    .din({selN, sclk, sdi, pauseN, wprotN}),
    .dout(pinS)
  );

  assign selNS = pinS[4];
  assign sclkS = pinS[3];
  assign sdiS = pinS[2];
  assign pauseNS = pinS[1];
  assign wprotNS = pinS[0];

  // Prev select resets low so a select held low from power-up never looks like a fall
  assign selFall = selPrev_q && !selNS;
  assign selRise = !selPrev_q && selNS;
  assign sclkRise = !sclkPrev_q && sclkS && selActive_q && !selNS && !paused_q;
  assign sclkFall = sclkPrev_q && !sclkS && selActive_q && !selNS && !paused_q;
  assign byteIn = {shiftIn_q[6:0], sdiS};
  assign statusWord = {lock_q, 3'h0, psize_q, wel_q, busy_q};
  assign frozen = lock_q && !wprotNS;

  // Frame end counts only if unpaused; a deselect in pause drops the command
  assign frameEnd = selRise && selActive_q && !paused_q;
  assign commitOk = frameEnd && state_q == S_WDATA && bitCnt_q == 3'h0 && gotData_q
                    && wel_q && !busy_q;
  assign memCommit = commitOk && cmd_q == C_MWRITE
                     && !sepp_protected(psize_q, space_q, startAddr_q);
  assign statCommit = commitOk && cmd_q == C_SWRITE && !frozen;
  assign armDone = frameEnd && state_q == S_ONEBYTE && bitCnt_q == 3'h0;

  always_ff @(posedge mclk or negedge rstN_q) begin
    if (!rstN_q) begin
      selPrev_q <= 1'h0;
      sclkPrev_q <= 1'h0;
      selActive_q <= 1'h0;
      paused_q <= 1'h0;
    end else begin
      selPrev_q <= selNS;
      sclkPrev_q <= sclkS;
      if (selFall) begin
        selActive_q <= 1'h1;
      end else if (selNS) begin
        selActive_q <= 1'h0;
      end
      if (selNS || !selActive_q) begin
        paused_q <= 1'h0;
      end else if (!paused_q && !pauseNS && !sclkS) begin
        paused_q <= 1'h1;
      end else if (paused_q && pauseNS && !sclkS) begin
        paused_q <= 1'h0;
      end
    end
  end

  // Command framing and decode
  always_ff @(posedge mclk or negedge rstN_q) begin
    if (!rstN_q) begin
      state_q <= S_IDLE;
      cmd_q <= C_NONE;
      space_q <= SP_ARRAY;
      bitCnt_q <= 3'h0;
      shiftIn_q <= 8'h00;
      addrHi_q <= 2'h0;
      addrCnt_q <= 1'h0;
      gotData_q <= 1'h0;
      memAddr_q <= 10'h000;
      startAddr_q <= 10'h000;
      newLock_q <= LOCK_RST;
      newPsize_q <= PSIZE_RST;
      wrByteStb_q <= 1'h0;
      wrByte_q <= 8'h00;
    end else begin
      wrByteStb_q <= 1'h0;
      if (selFall) begin
        state_q <= S_OPCODE;
        cmd_q <= C_NONE;
        bitCnt_q <= 3'h0;
        addrCnt_q <= 1'h0;
        gotData_q <= 1'h0;
      end else if (selNS || !selActive_q) begin
        state_q <= S_IDLE;
        bitCnt_q <= 3'h0;
      end else if (sclkRise) begin
        shiftIn_q <= byteIn;
        bitCnt_q <= bitCnt_q + 3'h1;
        if (bitCnt_q == 3'h7) begin
          case (state_q)
            S_OPCODE: begin
              // Only status read and disarm pass while a write cycle runs
              if (busy_q && byteIn != OP_STATUS_READ && byteIn != OP_WRITE_DISARM) begin
                state_q <= S_WAIT;
              end else begin
                case (byteIn)
                  OP_WRITE_ARM: begin
                    cmd_q <= C_ARM;
                    state_q <= S_ONEBYTE;
                  end
                  OP_WRITE_DISARM: begin
                    cmd_q <= C_DISARM;
                    state_q <= S_ONEBYTE;
                  end
                  OP_STATUS_READ: begin
                    cmd_q <= C_SREAD;
                    state_q <= S_RDATA;
                  end
                  OP_STATUS_WRITE: begin
                    cmd_q <= C_SWRITE;
                    state_q <= wel_q ? S_WDATA : S_WAIT;
                  end
                  OP_MEM_READ, OP_IDENT_READ: begin
                    cmd_q <= C_MREAD;
                    space_q <= (byteIn == OP_MEM_READ) ? SP_ARRAY : SP_IDENT;
                    state_q <= S_ADDR;
                  end
                  OP_MEM_WRITE, OP_IDENT_WRITE: begin
                    cmd_q <= C_MWRITE;
                    space_q <= (byteIn == OP_MEM_WRITE) ? SP_ARRAY : SP_IDENT;
                    state_q <= wel_q ? S_ADDR : S_WAIT;
                  end
                  default: begin
                    state_q <= S_WAIT;
                  end
                endcase
              end
            end
            S_ADDR: begin
              addrCnt_q <= 1'h1;
              addrHi_q <= byteIn[1:0];
              if (addrCnt_q) begin
                if (space_q == SP_ARRAY) begin
                  memAddr_q <= {addrHi_q, byteIn};
                  startAddr_q <= {addrHi_q, byteIn};
                end else begin
                  memAddr_q <= {2'h0, byteIn} & IDENT_ADDR_MASK;
                  startAddr_q <= {2'h0, byteIn} & IDENT_ADDR_MASK;
                  if (byteIn[LOCK_SEL_BIT]) begin
                    space_q <= SP_LOCK;
                  end
                end
                state_q <= (cmd_q == C_MREAD) ? S_RDATA : S_WDATA;
              end
            end
            S_WDATA: begin
              gotData_q <= 1'h1;
              if (cmd_q == C_SWRITE) begin
                newLock_q <= byteIn[ST_LOCK_BIT];
                newPsize_q <= byteIn[ST_PSIZE_HI:ST_PSIZE_LO];
              end else begin
                wrByteStb_q <= 1'h1;
                wrByte_q <= byteIn;
                memAddr_q <= stepAddr(space_q, memAddr_q);
              end
            end
            S_RDATA: begin
              if (cmd_q == C_MREAD) begin
                memAddr_q <= stepAddr(space_q, memAddr_q);
              end
            end
            S_ONEBYTE: begin
              state_q <= S_WAIT;
            end
            default: begin
              state_q <= state_q;
            end
          endcase
        end
      end
    end
  end

  // Write cycle, arm latch and nonvolatile status bits
  always_ff @(posedge mclk or negedge rstN_q) begin
    if (!rstN_q) begin
      busy_q <= 1'h0;
      busyCnt_q <= '0;
      statusCyc_q <= 1'h0;
      wel_q <= WEL_RST;
      lock_q <= LOCK_RST;
      psize_q <= PSIZE_RST;
      wrCommit_q <= 1'h0;
      wrAbort_q <= 1'h0;
    end else begin
      wrCommit_q <= memCommit;
      wrAbort_q <= selRise && selActive_q && cmd_q == C_MWRITE && !memCommit;
      if (memCommit || statCommit) begin
        busy_q <= 1'h1;
        busyCnt_q <= BUSY_CNT_W'(WRITE_CYCLES);
        statusCyc_q <= statCommit;
      end else if (busy_q) begin
        if (busyCnt_q == BUSY_CNT_W'(1)) begin
          busy_q <= 1'h0;
          wel_q <= 1'h0;
          // Recheck the pin: it may have dropped during the cycle
          if (statusCyc_q && !frozen) begin
            lock_q <= newLock_q;
            psize_q <= newPsize_q;
          end
        end else begin
          busyCnt_q <= busyCnt_q - BUSY_CNT_W'(1);
        end
      end else if (armDone && cmd_q == C_ARM) begin
        wel_q <= 1'h1;
      end
      if (armDone && cmd_q == C_DISARM) begin
        wel_q <= 1'h0;
      end
    end
  end

  assign loadByte = (cmd_q == C_SREAD) ? statusWord : memRdData;

  // Output shifter; count survives a pause so the byte resumes in place
  always_ff @(posedge mclk or negedge rstN_q) begin
    if (!rstN_q) begin
      sdoOut_q <= 1'h0;
      sdoOeN_q <= 1'h1;
      outSh_q <= 8'h00;
      outCnt_q <= 3'h0;
      outLoaded_q <= 1'h0;
      standby_q <= 1'h1;
      statusOut_q <= 8'h00;
    end else begin
      standby_q <= (selNS || !selActive_q) && !busy_q;
      statusOut_q <= statusWord;
      if (state_q != S_RDATA || selNS) begin
        sdoOeN_q <= 1'h1;
        outCnt_q <= 3'h0;
        outLoaded_q <= 1'h0;
      end else if (paused_q) begin
        sdoOeN_q <= 1'h1;
      end else if (sclkFall) begin
        outCnt_q <= outCnt_q + 3'h1;
        outLoaded_q <= 1'h1;
        sdoOeN_q <= 1'h0;
        if (outCnt_q == 3'h0) begin
          sdoOut_q <= loadByte[7];
          outSh_q <= {loadByte[6:0], 1'h0};
        end else begin
          sdoOut_q <= outSh_q[7];
          outSh_q <= {outSh_q[6:0], 1'h0};
        end
      end else begin
        sdoOeN_q <= !outLoaded_q;
      end
    end
  end

  assign sdoOut = sdoOut_q;
  assign sdoOeN = sdoOeN_q;
  assign standby = standby_q;
  assign memAddr = memAddr_q;
  assign memSpace = space_q;
  assign wrByteStb = wrByteStb_q;
  assign wrByte = wrByte_q;
  assign wrCommit = wrCommit_q;
  assign wrAbort = wrAbort_q;
  assign statusOut = statusOut_q;

  property p_pause_hiz;
    @(posedge mclk) disable iff (!rstN_q) paused_q |=> sdoOeN_q;
  endproperty
  a_pause_hiz: assert property (p_pause_hiz) else $error("output driven in pause");

  property p_pause_entry;
    @(posedge mclk) disable iff (!rstN_q) $rose(paused_q) |-> !$past(pauseNS) && !$past(sclkS);
  endproperty
  a_pause_entry: assert property (p_pause_entry) else $error("bad pause entry");

  property p_pause_exit;
    @(posedge mclk) disable iff (!rstN_q)
      $fell(paused_q) |-> $past(pauseNS) && !$past(sclkS) || $past(selNS);
  endproperty
  a_pause_exit: assert property (p_pause_exit) else $error("bad pause exit");

  property p_desel_reset;
    @(posedge mclk) disable iff (!rstN_q) (selNS && !selFall) |=> state_q == S_IDLE;
  endproperty
  a_desel_reset: assert property (p_desel_reset) else $error("kept after deselect");

  property p_standby;
    @(posedge mclk) disable iff (!rstN_q) (selNS && !busy_q) ##1 (selNS && !busy_q) |=> standby_q;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not entered");

  property p_needs_fall;
    @(posedge mclk) disable iff (!rstN_q) (state_q != S_IDLE) |-> selActive_q || $past(selNS);
  endproperty
  a_needs_fall: assert property (p_needs_fall) else $error("no select fall");

  property p_arm_gate;
    @(posedge mclk) disable iff (!rstN_q) $rose(busy_q) |-> $past(wel_q) && ~|$past(bitCnt_q);
  endproperty
  a_arm_gate: assert property (p_arm_gate) else $error("unarmed or torn write");

  property p_arm_clear;
    @(posedge mclk) disable iff (!rstN_q) $fell(busy_q) |-> !wel_q;
  endproperty
  a_arm_clear: assert property (p_arm_clear) else $error("arm kept after write");

  property p_frozen;
    @(posedge mclk) disable iff (!rstN_q)
      (lock_q && !wprotNS) ##1 !wprotNS |-> $stable(lock_q) && $stable(psize_q);
  endproperty
  a_frozen: assert property (p_frozen) else $error("frozen status changed");

  property p_status_layout;
    @(posedge mclk) disable iff (!rstN_q)
      ##1 statusOut_q[6:4] == 3'h0 && statusOut_q[ST_BUSY_BIT] == $past(busy_q);
  endproperty
  a_status_layout: assert property (p_status_layout) else $error("bad status bits");

  c_write_commit: cover property (@(posedge mclk) disable iff (!rstN_q) wrCommit_q);
  c_status_cycle: cover property (@(posedge mclk) disable iff (!rstN_q) busy_q && statusCyc_q);
  c_pause: cover property (@(posedge mclk) disable iff (!rstN_q) paused_q && state_q == S_RDATA);
  c_arm: cover property (@(posedge mclk) disable iff (!rstN_q) $rose(wel_q));

endmodule : sepp_top
